// ---- res_regs.sv ----
// Measurement result registers with byte register port and interrupt output
// Overview of operation
// - Infrared ambient result low byte readable at offset 0x24.
// - Infrared ambient result high byte, bits 15..8, at offset 0x25.
// - First proximity result: low byte 0x26, high byte 0x27.
// - Second proximity result: low byte 0x28, high byte 0x29.
// - Third proximity result: low byte 0x2a, high byte 0x2b.
// - Auxiliary result low byte readable at offset 0x2c.
// - All result registers clear to zero on reset.
// - Auxiliary result high byte at offset 0x2d, same read window.
// - Interrupt output asserts when a status bit and its enable are both set.
`timescale 1ns/100ps
module res_regs (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [res_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [res_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [res_pkg::DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic meas_wr_in,
  input wire logic [res_pkg::CH_W-1:0] meas_ch_in,
  input wire logic [res_pkg::RES_W-1:0] meas_data_in,
  output logic [res_pkg::NUM_CH-1:0] result_ready_out,
  input wire logic [res_pkg::IRQ_W-1:0] irq_status_in,
  input wire logic [res_pkg::IRQ_W-1:0] irq_enable_in,
  output logic irq_out,
  input wire logic [res_pkg::NUM_CH-1:0] overrun_clr_in,
  output logic [res_pkg::NUM_CH-1:0] unread_out,
  output logic [res_pkg::NUM_CH-1:0] overrun_out
);
  import res_pkg::*;

  logic acc_hit;
  logic acc_hi;
  logic [CH_W-1:0] acc_ch;
  logic meas_ok;
  logic [NUM_CH-1:0] upd;
  logic [NUM_CH-1:0] host_wr;
  logic [NUM_CH-1:0] hi_read;
  logic [NUM_CH-1:0] ready_d;
  logic irq_d;

  // Address decode into channel and byte half
  always_comb begin
    acc_hit = 1'b1;
    acc_hi = 1'b0;
    acc_ch = CH_IR;
    unique case (reg_addr_in)
      OFS_IR_LO: acc_ch = CH_IR;
      OFS_IR_HI: begin
        acc_ch = CH_IR;
        acc_hi = 1'b1;
      end
      OFS_P1_LO: acc_ch = CH_P1;
      OFS_P1_HI: begin
        acc_ch = CH_P1;
        acc_hi = 1'b1;
      end
      OFS_P2_LO: acc_ch = CH_P2;
      OFS_P2_HI: begin
        acc_ch = CH_P2;
        acc_hi = 1'b1;
      end
      OFS_P3_LO: acc_ch = CH_P3;
      OFS_P3_HI: begin
        acc_ch = CH_P3;
        acc_hi = 1'b1;
      end
      OFS_AUX_LO: acc_ch = CH_AUX;
      OFS_AUX_HI: begin
        acc_ch = CH_AUX;
        acc_hi = 1'b1;
      end
      default: acc_hit = 1'b0;
    endcase
  end

  // Channel numbers above the last one are dropped
  assign meas_ok = meas_wr_in && (meas_ch_in <= CH_AUX);

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_sel
      assign upd[i] = meas_ok && (meas_ch_in == CH_W'(i));
      assign host_wr[i] = reg_wr_in && acc_hit && (acc_ch == CH_W'(i));
      // High byte read closes the window, as the host reads low byte first
      assign hi_read[i] = reg_rd_in && acc_hit && acc_hi && (acc_ch == CH_W'(i));
    end
  endgenerate

  // Whole word written in one edge; no snapshot is taken, so an update between the two byte reads mixes the pair
  res_mem u_mem (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .word_wr_in(upd),
    .word_in(meas_data_in),
    .byte_wr_in(host_wr),
    .byte_hi_in(acc_hi),
    .byte_in(reg_wdata_in),
    .rd_en_in(reg_rd_in),
    .rd_hit_in(acc_hit),
    .rd_ch_in(acc_ch),
    .rd_hi_in(acc_hi),
    .rd_data_out(reg_rdata_out)
  );

  res_track u_track (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .upd_in(upd),
    .hi_read_in(hi_read),
    .ovr_clr_in(overrun_clr_in),
    .unread_out(unread_out),
    .overrun_out(overrun_out)
  );

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
    end
  end

  // Event leaves on the same edge the word lands, so the data is readable by then
  assign ready_d = upd;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      result_ready_out <= '0;
    end else begin
      result_ready_out <= ready_d;
    end
  end

  // Status clearing lives in the status logic; here only the gating
  assign irq_d = |(irq_status_in & irq_enable_in);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_d;
    end
  end

  // Checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  logic rst_seen_q;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rst_seen_q <= 1'b1;
    end else if (reg_rd_in || meas_wr_in || reg_wr_in) begin
      rst_seen_q <= 1'b0;
    end
  end

  sequence seq_update(logic [CH_W-1:0] ch);
    meas_wr_in && (meas_ch_in == ch);
  endsequence

  sequence seq_read(logic [ADDR_W-1:0] a);
    reg_rd_in && (reg_addr_in == a) && !meas_wr_in && !reg_wr_in;
  endsequence

  AST_IR_LO: assert property (seq_update(CH_IR) ##1 seq_read(OFS_IR_LO) |=>
    reg_rdata_out == $past(meas_data_in[7:0], 2))
    else $error("infrared low byte wrong");
  AST_IR_HI: assert property (seq_update(CH_IR) ##1 seq_read(OFS_IR_HI) |=>
    reg_rdata_out == $past(meas_data_in[15:8], 2))
    else $error("infrared high byte wrong");
  AST_P1_HI: assert property (seq_update(CH_P1) ##1 seq_read(OFS_P1_HI) |=>
    reg_rdata_out == $past(meas_data_in[15:8], 2))
    else $error("first proximity high byte wrong");
  AST_P2_LO: assert property (seq_update(CH_P2) ##1 seq_read(OFS_P2_LO) |=>
    reg_rdata_out == $past(meas_data_in[7:0], 2))
    else $error("second proximity low byte wrong");
  AST_P3_HI: assert property (seq_update(CH_P3) ##1 seq_read(OFS_P3_HI) |=>
    reg_rdata_out == $past(meas_data_in[15:8], 2))
    else $error("third proximity high byte wrong");
  AST_AUX_LO: assert property (seq_update(CH_AUX) ##1 seq_read(OFS_AUX_LO) |=>
    reg_rdata_out == $past(meas_data_in[7:0], 2))
    else $error("auxiliary low byte wrong");
  AST_AUX_HI: assert property (seq_update(CH_AUX) ##1 seq_read(OFS_AUX_HI) |=>
    reg_rdata_out == $past(meas_data_in[15:8], 2))
    else $error("auxiliary high byte wrong");
  AST_RESET_ZERO: assert property (rst_seen_q && reg_rd_in |=> reg_rdata_out == BYTE_ZERO)
    else $error("result not zero after reset");
  AST_IRQ: assert property (irq_d ##1 irq_d |-> irq_out ##1 (irq_out == $past(irq_d)))
    else $error("interrupt output not following status and enable");
  AST_READY: assert property (meas_ok |=> result_ready_out[$past(meas_ch_in)] && $onehot(result_ready_out))
    else $error("ready event missing after update");
  AST_OVERRUN: assert property ((upd & unread_out) != '0 |=>
    (overrun_out & $past(upd & unread_out)) == $past(upd & unread_out))
    else $error("overrun not flagged");

  sequence seq_write(logic [ADDR_W-1:0] a);
    reg_wr_in && (reg_addr_in == a) && !meas_wr_in;
  endsequence

  AST_P1_LO: assert property (seq_update(CH_P1) ##1 seq_read(OFS_P1_LO) |=>
    reg_rdata_out == $past(meas_data_in[7:0], 2))
    else $error("first proximity low byte wrong");
  AST_P2_HI: assert property (seq_update(CH_P2) ##1 seq_read(OFS_P2_HI) |=>
    reg_rdata_out == $past(meas_data_in[15:8], 2))
    else $error("second proximity high byte wrong");
  AST_P3_LO: assert property (seq_update(CH_P3) ##1 seq_read(OFS_P3_LO) |=>
    reg_rdata_out == $past(meas_data_in[7:0], 2))
    else $error("third proximity low byte wrong");
  AST_HOST_WR: assert property (seq_write(OFS_P3_HI) ##1 !(reg_wr_in || meas_wr_in) ##1 seq_read(OFS_P3_HI) |=>
    reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("host byte write not readable");
  AST_RVALID: assert property (1'b1 |=> reg_rvalid_out == $past(reg_rd_in))
    else $error("read valid not one cycle after read");
  AST_UNMAPPED: assert property (reg_rd_in && !acc_hit |=> reg_rdata_out == BYTE_ZERO)
    else $error("unmapped read not zero");
  AST_REFUSED: assert property (meas_wr_in && !meas_ok && hi_read == '0 |=>
    result_ready_out == '0 && $stable(unread_out))
    else $error("ignored channel raised an event");
  AST_UNREAD_SET: assert property (meas_ok |=> unread_out[$past(meas_ch_in)])
    else $error("unread not set by new result");
  AST_UNREAD_CLR: assert property (hi_read != '0 && !meas_wr_in |=> (unread_out & $past(hi_read)) == '0)
    else $error("unread not cleared by high byte read");
  AST_OVR_CLR: assert property ((overrun_clr_in & ~(upd & unread_out)) != '0 |=>
    (overrun_out & $past(overrun_clr_in & ~(upd & unread_out))) == '0)
    else $error("overrun not cleared");
endmodule

// ---- res_pkg.sv ----
// Shared constants for the optical sensor result register block
package res_pkg;
  localparam int NUM_CH = 5;
  localparam int CH_W = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int RES_W = 16;
  localparam int IRQ_W = 6;

  // Byte offsets of the result registers
  localparam logic [ADDR_W-1:0] OFS_IR_LO = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_IR_HI = 8'h25;
  localparam logic [ADDR_W-1:0] OFS_P1_LO = 8'h26;
  localparam logic [ADDR_W-1:0] OFS_P1_HI = 8'h27;
  localparam logic [ADDR_W-1:0] OFS_P2_LO = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_P2_HI = 8'h29;
  localparam logic [ADDR_W-1:0] OFS_P3_LO = 8'h2a;
  localparam logic [ADDR_W-1:0] OFS_P3_HI = 8'h2b;
  localparam logic [ADDR_W-1:0] OFS_AUX_LO = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_AUX_HI = 8'h2d;

  // Channel numbers as used on the measurement update port
  localparam logic [CH_W-1:0] CH_IR = 3'h0;
  localparam logic [CH_W-1:0] CH_P1 = 3'h1;
  localparam logic [CH_W-1:0] CH_P2 = 3'h2;
  localparam logic [CH_W-1:0] CH_P3 = 3'h3;
  localparam logic [CH_W-1:0] CH_AUX = 3'h4;

  // Byte field positions inside a 16-bit result
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 8;

  localparam logic [RES_W-1:0] RESULT_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
endpackage

// ---- res_mem.sv ----
// Result storage: one 16-bit word per channel, byte read port with registered data
`timescale 1ns/100ps
module res_mem (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [res_pkg::NUM_CH-1:0] word_wr_in,
  input wire logic [res_pkg::RES_W-1:0] word_in,
  input wire logic [res_pkg::NUM_CH-1:0] byte_wr_in,
  input wire logic byte_hi_in,
  input wire logic [res_pkg::DATA_W-1:0] byte_in,
  input wire logic rd_en_in,
  input wire logic rd_hit_in,
  input wire logic [res_pkg::CH_W-1:0] rd_ch_in,
  input wire logic rd_hi_in,
  output logic [res_pkg::DATA_W-1:0] rd_data_out
);
  import res_pkg::*;

  logic [RES_W-1:0] word_q [NUM_CH];

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_word
      // A finished measurement wins over a host byte write in the same cycle
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          word_q[i] <= RESULT_RESET;
        end else if (word_wr_in[i]) begin
          word_q[i] <= word_in;
        end else if (byte_wr_in[i] && byte_hi_in) begin
          word_q[i][HI_LSB +: DATA_W] <= byte_in;
        end else if (byte_wr_in[i]) begin
          word_q[i][LO_LSB +: DATA_W] <= byte_in;
        end
      end
    end
  endgenerate

  // Unmapped addresses read as zero
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= BYTE_ZERO;
    end else if (rd_en_in) begin
      if (!rd_hit_in) begin
        rd_data_out <= BYTE_ZERO;
      end else if (rd_hi_in) begin
        rd_data_out <= word_q[rd_ch_in][HI_LSB +: DATA_W];
      end else begin
        rd_data_out <= word_q[rd_ch_in][LO_LSB +: DATA_W];
      end
    end
  end
endmodule

// ---- res_track.sv ----
// Per-channel unread and overrun flags for the host read window
`timescale 1ns/100ps
module res_track (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [res_pkg::NUM_CH-1:0] upd_in,
  input wire logic [res_pkg::NUM_CH-1:0] hi_read_in,
  input wire logic [res_pkg::NUM_CH-1:0] ovr_clr_in,
  output logic [res_pkg::NUM_CH-1:0] unread_out,
  output logic [res_pkg::NUM_CH-1:0] overrun_out
);
  import res_pkg::*;

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_ch
      // New result wins over a read of the previous one
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          unread_out[i] <= 1'b0;
        end else if (upd_in[i]) begin
          unread_out[i] <= 1'b1;
        end else if (hi_read_in[i]) begin
          unread_out[i] <= 1'b0;
        end
      end

      // Host missed its window: sticky, setting wins over clearing
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          overrun_out[i] <= 1'b0;
        end else if (upd_in[i] && unread_out[i]) begin
          overrun_out[i] <= 1'b1;
        end else if (ovr_clr_in[i]) begin
          overrun_out[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

// ---- host_model.sv ----
// Host processor model that reads and writes the result byte port
`timescale 1ns/100ps
module host_model (
  input wire logic mclk_in,
  input wire logic [res_pkg::DATA_W-1:0] rdata_in,
  input wire logic rvalid_in,
  input wire logic irq_in,
  output logic [res_pkg::ADDR_W-1:0] addr_out,
  output logic wr_out,
  output logic [res_pkg::DATA_W-1:0] wdata_out,
  output logic rd_out
);
  import res_pkg::*;
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    wdata_out = 8'h00;
    rd_out = 1'b0;
  end
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    int i;
    @(negedge mclk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge mclk_in);
    rd_out = 1'b0;
    // Released address flips so a stale value cannot hide a decode slip
    addr_out = ~a;
    for (i = 0; i < 4 && rvalid_in !== 1'b1; i++) @(negedge mclk_in);
    // A missing valid hands back unknown so the caller's compare fails
    d = (rvalid_in === 1'b1) ? rdata_in : 'x;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(negedge mclk_in);
    addr_out = a;
    wdata_out = v;
    wr_out = 1'b1;
    @(negedge mclk_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~v;
  endtask
  // Low byte first: reading the high byte ends the unread state
  task automatic rd_word(input logic [ADDR_W-1:0] lo, output logic [RES_W-1:0] w, output logic irq_seen);
    int i;
    for (i = 0; i < 8 && irq_in !== 1'b1; i++) @(negedge mclk_in);
    irq_seen = irq_in;
    rd(lo, w[7:0]);
    rd(lo + 8'h01, w[15:8]);
  endtask
endmodule

// ---- optical_sensor_result_regs_bench.sv ----
// Self-checking bench for the result register block
`timescale 1ns/100ps
module optical_sensor_result_regs_bench;
  import res_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in, reg_wr, reg_rd, reg_rvalid, meas_wr_in, irq, s;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, b;
  logic [CH_W-1:0] meas_ch_in;
  logic [RES_W-1:0] meas_data_in, w;
  logic [NUM_CH-1:0] ready, ovr_clr, unread, overrun;
  logic [IRQ_W-1:0] irq_status, irq_enable;
  int fail_count = 0;
  int n_tests = 0;
  logic [ADDR_W-1:0] lo_ofs [NUM_CH] = '{OFS_IR_LO, OFS_P1_LO, OFS_P2_LO, OFS_P3_LO, OFS_AUX_LO};
  logic [RES_W-1:0] pat [NUM_CH] = '{16'h12a4, 16'h34b6, 16'h56c8, 16'h78da, 16'h9aec};
  res_regs uut (.mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr), .reg_wr_in(reg_wr),
    .reg_wdata_in(reg_wdata), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .reg_rvalid_out(reg_rvalid),
    .meas_wr_in(meas_wr_in), .meas_ch_in(meas_ch_in), .meas_data_in(meas_data_in), .result_ready_out(ready),
    .irq_status_in(irq_status), .irq_enable_in(irq_enable), .irq_out(irq), .overrun_clr_in(ovr_clr),
    .unread_out(unread), .overrun_out(overrun));
  host_model host (.mclk_in(mclk_in), .rdata_in(reg_rdata), .rvalid_in(reg_rvalid), .irq_in(irq),
    .addr_out(reg_addr), .wr_out(reg_wr), .wdata_out(reg_wdata), .rd_out(reg_rd));
  // Clock starts low at declaration, so no false falling edge at time zero
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic meas(input logic [CH_W-1:0] ch, input logic [RES_W-1:0] v);
    @(negedge mclk_in);
    meas_wr_in = 1'b1;
    meas_ch_in = ch;
    meas_data_in = v;
    @(negedge mclk_in);
    meas_wr_in = 1'b0;
    meas_data_in = ~v;
    chk("ready", 16'(ready), (ch < 5) ? 16'(5'h01 << ch) : 16'h0000);
  endtask
  task automatic t_reset();
    for (int i = 0; i < NUM_CH; i++) begin
      host.rd(lo_ofs[i], b);
      chk("reset lo", 16'(b), 16'h0000);
      host.rd(lo_ofs[i] + 8'h01, b);
      chk("reset hi", 16'(b), 16'h0000);
    end
  endtask
  task automatic t_map();
    irq_enable = 6'h3f;
    for (int i = 0; i < NUM_CH; i++) begin
      meas(i[CH_W-1:0], pat[i]);
      chk("unread set", 16'(unread), 16'(5'h01 << i));
      irq_status = 6'h01 << i;
      host.rd_word(lo_ofs[i], w, s);
      chk("irq", 16'(s), 16'h0001);
      chk("word", w, pat[i]);
      chk("unread clr", 16'(unread), 16'h0000);
      irq_status = 6'h00;
      repeat (2) @(negedge mclk_in);
      chk("irq drop", 16'(irq), 16'h0000);
    end
  endtask
  task automatic t_mask();
    irq_enable = 6'h00;
    irq_status = 6'h3f;
    repeat (2) @(negedge mclk_in);
    chk("irq masked", 16'(irq), 16'h0000);
    irq_enable = 6'h04;
    repeat (2) @(negedge mclk_in);
    chk("irq enabled", 16'(irq), 16'h0001);
    irq_status = 6'h00;
  endtask
  task automatic t_overrun();
    meas(CH_P2, 16'h0f1e);
    meas(CH_P2, 16'he1f0);
    chk("overrun", 16'(overrun), 16'h0004);
    host.rd_word(OFS_P2_LO, w, s);
    chk("latest", w, 16'he1f0);
    @(negedge mclk_in);
    ovr_clr = 5'h04;
    @(negedge mclk_in);
    ovr_clr = 5'h00;
    chk("overrun clr", 16'(overrun), 16'h0000);
  endtask
  task automatic t_quick();
    logic [RES_W-1:0] v;
    for (int i = 0; i < NUM_CH; i++) begin
      v = ~pat[i];
      for (int h = 0; h < 2; h++) begin
        @(negedge mclk_in);
        meas_wr_in = 1'b1;
        meas_ch_in = i[CH_W-1:0];
        meas_data_in = v;
        // Read issued in the cycle right after the result lands
        fork
          begin
            @(negedge mclk_in);
            meas_wr_in = 1'b0;
            meas_data_in = ~v;
          end
          host.rd(lo_ofs[i] + ADDR_W'(h), b);
        join
        chk("quick", 16'(b), 16'((h != 0) ? v[15:8] : v[7:0]));
      end
    end
    chk("overrun all", 16'(overrun), 16'h001f);
  endtask
  task automatic t_write();
    meas(3'h7, 16'hffff);
    chk("ignored unread", 16'(unread), 16'h0000);
    host.wr(OFS_P3_HI, 8'h5e);
    host.rd(OFS_P3_HI, b);
    chk("rw", 16'(b), 16'h005e);
    // Unmapped place: write lost, read gives zero
    host.wr(8'h30, 8'ha5);
    host.rd(8'h30, b);
    chk("unmapped", 16'(b), 16'h0000);
  endtask
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
  initial begin
    rst_in = 1'b1;
    meas_wr_in = 1'b0;
    meas_ch_in = 3'h0;
    meas_data_in = 16'h0000;
    irq_status = 6'h00;
    irq_enable = 6'h00;
    ovr_clr = 5'h00;
    repeat (10) @(negedge mclk_in);
    rst_in = 1'b0;
    t_reset();
    t_map();
    t_mask();
    t_overrun();
    t_write();
    t_quick();
    rst_in = 1'b1;
    repeat (10) @(negedge mclk_in);
    rst_in = 1'b0;
    t_reset();
    final_report();
  end
endmodule
